// [src/serial_ctrl_pkg.sv]
// shared constants for the serial control register block
package serial_ctrl_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FORMAT = 4'h0;
    localparam logic [3:0] ADDR_TXRX = 4'h4;
    localparam logic [3:0] ADDR_NINTH = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    // format register
    localparam int FMT_MODULE_ON = 6;
    localparam int FMT_CHAR_LEN = 4;
    localparam int FMT_RESUME = 3;
    localparam int FMT_PARITY_ON = 1;
    localparam int FMT_PARITY_ODD = 0;
    // transmit/receive control register
    localparam int TXR_TX_EMPTY_IE = 7;
    localparam int TXR_TX_DONE_IE = 6;
    localparam int TXR_RX_FULL_IE = 5;
    localparam int TXR_IDLE_IE = 4;
    localparam int TXR_TX_ENABLE = 3;
    localparam int TXR_RX_ON = 2;
    localparam int TXR_STANDBY = 1;
    localparam int TXR_BREAK = 0;
    // ninth bit and error enable register
    localparam int NB_RX_NINTH = 7;
    localparam int NB_TX_NINTH = 6;
    localparam int NB_OVERRUN_IE = 3;
    localparam int NB_NOISE_IE = 2;
    localparam int NB_FRAMING_IE = 1;
    localparam int NB_PARITY_IE = 0;
    // ------------------------------------------------------------
    // reset values and frame sizes
    // ------------------------------------------------------------
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [7:0] TXRX_RESET = 8'h00;
    localparam logic [5:0] ERR_IE_RESET = 6'h00;
    localparam logic [3:0] FRAME_BITS_SHORT = 4'ha;
    localparam logic [3:0] FRAME_BITS_LONG = 4'hb;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // transmitter phases
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PREAMBLE = 2'b01,
        TX_BREAK = 2'b10,
        TX_STOP_ONE = 2'b11
    } tx_phase_t;
endpackage : serial_ctrl_pkg

// [src/async_serial_ctrl_regs.sv]
// control registers and frame sequencing of an asynchronous serial transceiver
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module async_serial_ctrl_regs (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // axi4-lite write address and data
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // status flags from the transceiver core
    input wire logic TX_BUF_EMPTY_FLAG,
    input wire logic TX_COMPLETE_FLAG,
    input wire logic RX_FULL_FLAG,
    input wire logic LINE_QUIET_FLAG,
    input wire logic OVERRUN_FLAG,
    input wire logic NOISE_FLAG,
    input wire logic FRAME_ERR_FLAG,
    input wire logic PARITY_FAULT_FLAG,
    // receive path: character moved into the data buffer
    input wire logic RX_LOAD,
    input wire logic [8:0] RX_CHAR,
    // transmit path: data buffer moved into the shift register
    input wire logic TX_LOAD,
    input wire logic BIT_TICK,
    input wire logic CHAR_BUSY,
    // control outputs
    output logic MODULE_ON,
    output logic CHAR_LEN_SEL,
    output logic PARITY_ON,
    output logic PARITY_ODD_SEL,
    output logic RX_ON,
    output logic TX_NINTH_LOADED,
    output logic SERIAL_OUT_PIN,
    // interrupt requests
    output logic TX_IRQ,
    output logic RX_IRQ,
    output logic ERR_IRQ
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] format_reg;
    logic [7:0] irq_txrx_control;
    logic [5:0] err_ie;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic do_write;
    logic tx_enable;
    logic send_break_ctl;
    logic rx_standby;
    serial_ctrl_pkg::tx_phase_t tx_phase;
    logic [3:0] bit_count;
    logic [3:0] frame_bits;
    logic queue_idle;
    logic tx_enable_d;
    logic wake_event;
    logic standby_set;

    assign tx_enable = irq_txrx_control[serial_ctrl_pkg::TXR_TX_ENABLE];
    assign send_break_ctl = irq_txrx_control[serial_ctrl_pkg::TXR_BREAK];
    assign rx_standby = irq_txrx_control[serial_ctrl_pkg::TXR_STANDBY];
    assign frame_bits = format_reg[serial_ctrl_pkg::FMT_CHAR_LEN] ?
        serial_ctrl_pkg::FRAME_BITS_LONG : serial_ctrl_pkg::FRAME_BITS_SHORT;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    // address and data are captured independently so either may come first
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY = !w_held && !BVALID;
    assign do_write = aw_held && w_held && !BVALID;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= serial_ctrl_pkg::AXI_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA[7:0];
                w_lane0 <= WSTRB[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                BVALID <= 1'b1;
                // the status word and unknown offsets refuse writes
                BRESP <= (aw_addr == serial_ctrl_pkg::ADDR_FORMAT ||
                          aw_addr == serial_ctrl_pkg::ADDR_TXRX ||
                          aw_addr == serial_ctrl_pkg::ADDR_NINTH) ?
                         serial_ctrl_pkg::AXI_OKAY : serial_ctrl_pkg::AXI_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // format register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            format_reg <= serial_ctrl_pkg::FORMAT_RESET;
        end else if (do_write && w_lane0 && aw_addr == serial_ctrl_pkg::ADDR_FORMAT) begin
            // parity sense is taken as written; a mid-character change is software's risk
            format_reg <= w_data;
        end
    end

    assign MODULE_ON = format_reg[serial_ctrl_pkg::FMT_MODULE_ON];
    assign CHAR_LEN_SEL = format_reg[serial_ctrl_pkg::FMT_CHAR_LEN];
    assign PARITY_ON = format_reg[serial_ctrl_pkg::FMT_PARITY_ON];
    assign PARITY_ODD_SEL = format_reg[serial_ctrl_pkg::FMT_PARITY_ODD];
    assign RX_ON = irq_txrx_control[serial_ctrl_pkg::TXR_RX_ON];

    // ------------------------------------------------------------
    // standby wake detection
    // ------------------------------------------------------------
    // address mark looks at the top bit of whatever character length is active
    assign wake_event = format_reg[serial_ctrl_pkg::FMT_RESUME] ?
        (RX_LOAD && (CHAR_LEN_SEL ? RX_CHAR[8] : RX_CHAR[7])) :
        LINE_QUIET_FLAG;
    assign standby_set = do_write && w_lane0 && aw_addr == serial_ctrl_pkg::ADDR_TXRX &&
        w_data[serial_ctrl_pkg::TXR_STANDBY];

    // ------------------------------------------------------------
    // transmit/receive control register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            irq_txrx_control <= serial_ctrl_pkg::TXRX_RESET;
        end else begin
            if (do_write && w_lane0 && aw_addr == serial_ctrl_pkg::ADDR_TXRX) begin
                // enables are stored as written; software keeps them still while off
                irq_txrx_control <= w_data;
            end
            // a software write of the standby bit wins over wake in the same cycle
            if (rx_standby && wake_event && !standby_set) begin
                irq_txrx_control[serial_ctrl_pkg::TXR_STANDBY] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // ninth bit and error enable register
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            err_ie <= serial_ctrl_pkg::ERR_IE_RESET;
        end else if (do_write && w_lane0 && aw_addr == serial_ctrl_pkg::ADDR_NINTH) begin
            err_ie <= w_data[5:0];
        end
    end

    // the ninth bits keep their value through reset, so no reset branch
    always_ff @(posedge MCLK) begin
        if (do_write && w_lane0 && aw_addr == serial_ctrl_pkg::ADDR_NINTH) begin
            tx_ninth_bit <= w_data[serial_ctrl_pkg::NB_TX_NINTH];
        end
        if (RX_LOAD) begin
            rx_ninth_bit <= CHAR_LEN_SEL ? RX_CHAR[8] : RX_CHAR[7];
        end
    end

    // transmit bit 8 is latched with the data buffer into the shifter
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            TX_NINTH_LOADED <= 1'b0;
        end else if (TX_LOAD) begin
            TX_NINTH_LOADED <= CHAR_LEN_SEL & tx_ninth_bit;
        end
    end

    // ------------------------------------------------------------
    // transmit line sequencing: preamble, idle, break
    // ------------------------------------------------------------
    // a character owned by the core shifter has priority; this logic only
    // drives the line between characters, one bit per BIT_TICK
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            tx_phase <= serial_ctrl_pkg::TX_IDLE;
            bit_count <= 4'h0;
            queue_idle <= 1'b0;
            tx_enable_d <= 1'b0;
        end else begin
            tx_enable_d <= tx_enable;
            // off then on while busy queues exactly one idle character
            if (CHAR_BUSY && !tx_enable_d && tx_enable) begin
                queue_idle <= 1'b1;
            end
            case (tx_phase)
                serial_ctrl_pkg::TX_IDLE: begin
                    if (!CHAR_BUSY && send_break_ctl && tx_enable) begin
                        // a break requested before the preamble replaces it
                        tx_phase <= serial_ctrl_pkg::TX_BREAK;
                        bit_count <= 4'h0;
                    end else if (!CHAR_BUSY && tx_enable && (!tx_enable_d || queue_idle)) begin
                        tx_phase <= serial_ctrl_pkg::TX_PREAMBLE;
                        bit_count <= 4'h0;
                        queue_idle <= 1'b0;
                    end
                end
                serial_ctrl_pkg::TX_PREAMBLE: begin
                    if (BIT_TICK) begin
                        if (bit_count == frame_bits - 4'h1) begin
                            tx_phase <= serial_ctrl_pkg::TX_IDLE;
                        end else begin
                            bit_count <= bit_count + 4'h1;
                        end
                    end
                end
                serial_ctrl_pkg::TX_BREAK: begin
                    if (BIT_TICK) begin
                        if (bit_count == frame_bits - 4'h1) begin
                            bit_count <= 4'h0;
                            // held break repeats with no ones between
                            if (!send_break_ctl) begin
                                tx_phase <= serial_ctrl_pkg::TX_STOP_ONE;
                            end
                        end else begin
                            bit_count <= bit_count + 4'h1;
                        end
                    end
                end
                serial_ctrl_pkg::TX_STOP_ONE: begin
                    if (BIT_TICK) begin
                        tx_phase <= serial_ctrl_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_phase <= serial_ctrl_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // line level: break low, everything else high; idle high when disabled
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            SERIAL_OUT_PIN <= 1'b1;
        end else begin
            SERIAL_OUT_PIN <= (tx_phase != serial_ctrl_pkg::TX_BREAK);
        end
    end

    // ------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            TX_IRQ <= 1'b0;
            RX_IRQ <= 1'b0;
            ERR_IRQ <= 1'b0;
        end else begin
            TX_IRQ <= (TX_BUF_EMPTY_FLAG & irq_txrx_control[serial_ctrl_pkg::TXR_TX_EMPTY_IE]) |
                      (TX_COMPLETE_FLAG & irq_txrx_control[serial_ctrl_pkg::TXR_TX_DONE_IE]);
            RX_IRQ <= !rx_standby &&
                      ((RX_FULL_FLAG && irq_txrx_control[serial_ctrl_pkg::TXR_RX_FULL_IE]) ||
                       (LINE_QUIET_FLAG && irq_txrx_control[serial_ctrl_pkg::TXR_IDLE_IE]));
            ERR_IRQ <= !rx_standby &&
                       ((OVERRUN_FLAG && err_ie[serial_ctrl_pkg::NB_OVERRUN_IE]) ||
                        (NOISE_FLAG && err_ie[serial_ctrl_pkg::NB_NOISE_IE]) ||
                        (FRAME_ERR_FLAG && err_ie[serial_ctrl_pkg::NB_FRAMING_IE]) ||
                        (PARITY_FAULT_FLAG && err_ie[serial_ctrl_pkg::NB_PARITY_IE]));
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    assign ARREADY = !RVALID;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= serial_ctrl_pkg::AXI_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= serial_ctrl_pkg::AXI_OKAY;
            case (ARADDR)
                serial_ctrl_pkg::ADDR_FORMAT: RDATA <= {24'h0, format_reg};
                serial_ctrl_pkg::ADDR_TXRX: RDATA <= {24'h0, irq_txrx_control};
                serial_ctrl_pkg::ADDR_NINTH: RDATA <= {24'h0, rx_ninth_bit, tx_ninth_bit, err_ie};
                serial_ctrl_pkg::ADDR_STATUS: RDATA <= {24'h0, TX_BUF_EMPTY_FLAG,
                    TX_COMPLETE_FLAG, RX_FULL_FLAG, LINE_QUIET_FLAG, OVERRUN_FLAG,
                    NOISE_FLAG, FRAME_ERR_FLAG, PARITY_FAULT_FLAG};
                default: begin
                    RDATA <= 32'h0;
                    RRESP <= serial_ctrl_pkg::AXI_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule : async_serial_ctrl_regs

// [test/serial_ctrl_properties.sv]
// port-level checks for the serial control register block
`timescale 1ns/1ps
module serial_ctrl_properties (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // bus answers
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    // core flags and loads
    input wire logic TX_BUF_EMPTY_FLAG,
    input wire logic TX_COMPLETE_FLAG,
    input wire logic RX_FULL_FLAG,
    input wire logic LINE_QUIET_FLAG,
    input wire logic OVERRUN_FLAG,
    input wire logic NOISE_FLAG,
    input wire logic FRAME_ERR_FLAG,
    input wire logic PARITY_FAULT_FLAG,
    input wire logic TX_LOAD,
    input wire logic CHAR_LEN_SEL,
    input wire logic TX_NINTH_LOADED,
    // requests
    input wire logic TX_IRQ,
    input wire logic RX_IRQ,
    input wire logic ERR_IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // answers stand until taken, so software never loses a response
    a_bresp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_rdata_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    a_ar_blocked: assert property (RVALID |-> !ARREADY)
        else $error("read address taken while answer pending");
    a_upper_zero: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // a request needs a live flag one cycle earlier
    a_tx_irq_cause: assert property (TX_IRQ |-> $past(TX_BUF_EMPTY_FLAG || TX_COMPLETE_FLAG))
        else $error("transmit request without flag");
    a_rx_irq_cause: assert property (RX_IRQ |-> $past(RX_FULL_FLAG || LINE_QUIET_FLAG))
        else $error("receive request without flag");
    a_err_irq_cause: assert property (ERR_IRQ |->
        $past(OVERRUN_FLAG || NOISE_FLAG || FRAME_ERR_FLAG || PARITY_FAULT_FLAG))
        else $error("error request without flag");
    a_ninth_short: assert property (TX_LOAD && !CHAR_LEN_SEL |=> !TX_NINTH_LOADED)
        else $error("ninth bit loaded in eight-bit mode");
endmodule : serial_ctrl_properties

bind async_serial_ctrl_regs serial_ctrl_properties u_props (.MCLK(MCLK), .RESET(RESET),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARREADY(ARREADY), .RVALID(RVALID),
    .RREADY(RREADY), .RDATA(RDATA), .TX_BUF_EMPTY_FLAG(TX_BUF_EMPTY_FLAG),
    .TX_COMPLETE_FLAG(TX_COMPLETE_FLAG), .RX_FULL_FLAG(RX_FULL_FLAG),
    .LINE_QUIET_FLAG(LINE_QUIET_FLAG), .OVERRUN_FLAG(OVERRUN_FLAG), .NOISE_FLAG(NOISE_FLAG),
    .FRAME_ERR_FLAG(FRAME_ERR_FLAG), .PARITY_FAULT_FLAG(PARITY_FAULT_FLAG),
    .TX_LOAD(TX_LOAD), .CHAR_LEN_SEL(CHAR_LEN_SEL), .TX_NINTH_LOADED(TX_NINTH_LOADED),
    .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ), .ERR_IRQ(ERR_IRQ));

// [test/far_serial.sv]
// far-side model: bit clock source and line watcher
`timescale 1ns/1ps
module far_serial #(parameter int TICK_DIV = 4) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line and bit clock
    input wire logic line,
    output logic tick,
    output int low_ticks
);
    int div;
    // short bit time so a whole frame fits in a few dozen cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div <= 0;
            tick <= 1'b0;
        end else begin
            div <= (div == TICK_DIV - 1) ? 0 : div + 1;
            tick <= (div == TICK_DIV - 1);
        end
    end
    // bit times seen low; whole breaks are frames of 10 or 11 bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_ticks <= 0;
        end else if (tick && !line) begin
            low_ticks <= low_ticks + 1;
        end
    end
endmodule : far_serial

// [test/tb.sv]
// self-checking bench for the serial control register block
`timescale 1ns/1ps
module tb;
    typedef struct {logic [3:0] a; logic [7:0] w; logic [1:0] br; logic [31:0] rv;} row_t;
    localparam logic [1:0] OK = serial_ctrl_pkg::AXI_OKAY;
    localparam logic [1:0] ER = serial_ctrl_pkg::AXI_SLVERR;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic RX_LOAD = 1'b0, TX_LOAD = 1'b0, AWREADY, WREADY, BVALID, ARREADY, RVALID, BIT_TICK;
    logic busy = 1'b0;
    logic TX_NINTH_LOADED, SERIAL_OUT_PIN, TX_IRQ, RX_IRQ, ERR_IRQ;
    logic [31:0] WDATA = 32'h0, RDATA, d;
    logic [7:0] flg = 8'h00;
    logic [8:0] RX_CHAR = 9'h000;
    logic [1:0] BRESP, RRESP, r;
    int n_fail = 0, checks = 0, cyc = 0, low_ticks, base, i, j;
    row_t rows [6] = '{'{4'h0, 8'h50, OK, 32'h50}, '{4'h4, 8'hf0, OK, 32'hf0},
        '{4'h8, 8'h0f, OK, 32'h8f}, '{4'h8, 8'h4f, OK, 32'hcf},
        '{4'hc, 8'hff, ER, 32'h00}, '{4'h2, 8'h11, ER, 32'h00}};
    always #50 MCLK = ~MCLK;
    async_serial_ctrl_regs DUT (.MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .TX_BUF_EMPTY_FLAG(flg[7]), .TX_COMPLETE_FLAG(flg[6]), .RX_FULL_FLAG(flg[5]),
        .LINE_QUIET_FLAG(flg[4]), .OVERRUN_FLAG(flg[3]), .NOISE_FLAG(flg[2]),
        .FRAME_ERR_FLAG(flg[1]), .PARITY_FAULT_FLAG(flg[0]), .RX_LOAD(RX_LOAD),
        .RX_CHAR(RX_CHAR), .TX_LOAD(TX_LOAD), .BIT_TICK(BIT_TICK), .CHAR_BUSY(busy),
        .MODULE_ON(), .CHAR_LEN_SEL(), .PARITY_ON(), .PARITY_ODD_SEL(), .RX_ON(),
        .TX_NINTH_LOADED(TX_NINTH_LOADED), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
        .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ), .ERR_IRQ(ERR_IRQ));
    far_serial #(.TICK_DIV(4)) u_far (.clk(MCLK), .rst(RESET), .line(SERIAL_OUT_PIN),
        .tick(BIT_TICK), .low_ticks(low_ticks));
    // ------------------------------------------------------------
    // reporting and compares
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t resp %h expected %h", $time, got, exp);
        end
    endtask : chk_resp
    // ------------------------------------------------------------
    // bus and core stimulus
    // ------------------------------------------------------------
    // address and data offered together, each released once taken
    task automatic wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] rsp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= {24'h0, v};
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        forever begin
            @(posedge MCLK);
            if (AWREADY && !aw_done) begin
                aw_done = 1'b1;
                AWVALID <= 1'b0;
            end
            if (WREADY && !w_done) begin
                w_done = 1'b1;
                WVALID <= 1'b0;
            end
            if (BVALID) begin
                rsp = BRESP;
                BREADY <= 1'b0;
                break;
            end
        end
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
        logic ar_done;
        ar_done = 1'b0;
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        forever begin
            @(posedge MCLK);
            if (ARREADY && !ar_done) begin
                ar_done = 1'b1;
                ARVALID <= 1'b0;
            end
            if (RVALID) begin
                v = RDATA;
                rsp = RRESP;
                RREADY <= 1'b0;
                break;
            end
        end
    endtask : rd
    task automatic pulse(input logic rx, input logic [8:0] c);
        @(posedge MCLK);
        RX_CHAR <= c;
        RX_LOAD <= rx;
        TX_LOAD <= !rx;
        @(posedge MCLK);
        RX_LOAD <= 1'b0;
        TX_LOAD <= 1'b0;
        repeat (2) @(posedge MCLK);
    endtask : pulse
    // hang guard, well above the several hundred cycles the run needs
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        rd(4'h4, d, r);
        chk_val(d, 32'h0);
        rd(4'h8, d, r);
        chk_val(d & 32'h3f, 32'h0);
        $display("test reset done");
        pulse(1'b1, 9'h080);
        // module_on is written first so later enables are legal
        for (i = 0; i < 6; i++) begin
            wr(rows[i].a, rows[i].w, r);
            chk_resp(r, rows[i].br);
            rd(rows[i].a, d, r);
            chk_val(d, rows[i].rv);
            chk_resp(r, rows[i].a == 4'h2 ? ER : OK);
        end
        $display("test registers done");
        pulse(1'b1, 9'h0ff);
        rd(4'h8, d, r);
        chk_val(d, 32'h4f);
        pulse(1'b1, 9'h100);
        rd(4'h8, d, r);
        chk_val(d, 32'hcf);
        pulse(1'b0, 9'h000);
        chk_val(TX_NINTH_LOADED, 32'h1);
        wr(4'h0, 8'h40, r);
        pulse(1'b0, 9'h000);
        chk_val(TX_NINTH_LOADED, 32'h0);
        pulse(1'b1, 9'h100);
        rd(4'h8, d, r);
        chk_val(d, 32'h4f);
        wr(4'h0, 8'h50, r);
        $display("test ninth bit done");
        // each flag alone, first with enables on, then with them off
        for (j = 0; j < 2; j++) begin
            for (i = 0; i < 8; i++) begin
                flg <= 8'h80 >> i;
                repeat (3) @(posedge MCLK);
                chk_val({TX_IRQ, RX_IRQ, ERR_IRQ},
                    j ? 32'h0 : {29'h0, i < 2, i == 2 || i == 3, i > 3});
            end
            flg <= 8'h00;
            wr(4'h4, 8'h00, r);
            wr(4'h8, 8'h40, r);
        end
        wr(4'h4, 8'h22, r);
        flg <= 8'h20;
        repeat (3) @(posedge MCLK);
        chk_val(RX_IRQ, 32'h0);
        flg <= 8'h30;
        repeat (2) @(posedge MCLK);
        flg <= 8'h20;
        rd(4'h4, d, r);
        chk_val(d, 32'h20);
        chk_val(RX_IRQ, 32'h1);
        flg <= 8'h00;
        // address-mark wake: only a character with its top bit set ends standby
        wr(4'h0, 8'h58, r);
        wr(4'h4, 8'h22, r);
        pulse(1'b1, 9'h0ff);
        rd(4'h4, d, r);
        chk_val(d, 32'h22);
        pulse(1'b1, 9'h100);
        rd(4'h4, d, r);
        chk_val(d, 32'h20);
        wr(4'h0, 8'h50, r);
        $display("test interrupts done");
        wr(4'h4, 8'h08, r);
        for (i = 0; i < 11; i++) begin
            @(posedge MCLK iff BIT_TICK);
            chk_val(SERIAL_OUT_PIN, 32'h1);
        end
        // a break requested before the preamble replaces it; here the preamble has already run
        busy <= 1'b1;
        wr(4'h4, 8'h09, r);
        // a character owned by the core keeps the line high
        repeat (12) @(posedge MCLK iff BIT_TICK);
        chk_val(SERIAL_OUT_PIN, 32'h1);
        busy <= 1'b0;
        for (i = 0; i < 400 && SERIAL_OUT_PIN; i++) @(posedge MCLK);
        base = low_ticks;
        repeat (30) @(posedge MCLK iff BIT_TICK);
        chk_val(SERIAL_OUT_PIN, 32'h0);
        wr(4'h4, 8'h08, r);
        for (i = 0; i < 400 && !SERIAL_OUT_PIN; i++) @(posedge MCLK);
        chk_val((low_ticks - base) % serial_ctrl_pkg::FRAME_BITS_LONG, 32'h0);
        @(posedge MCLK iff BIT_TICK);
        chk_val(SERIAL_OUT_PIN, 32'h1);
        $display("test line done");
        tally_and_finish();
    end
endmodule : tb
